// *** dbgbrk_params.svh ***
// dbgbrk_params.svh: constants of the breakpoint control block
// assumes inclusion by the package and the modules of this block only
`ifndef DBGBRK_PARAMS_SVH
`define DBGBRK_PARAMS_SVH

`define DBGBRK_BREAK_OPCODE    8'h00
`define DBGBRK_ADDR_W          4
`define DBGBRK_ADDR_CTRL       4'h0
`define DBGBRK_ADDR_STAT       4'h1
`define DBGBRK_ADDR_IRQ_STAT   4'h2
`define DBGBRK_ADDR_IRQ_EN     4'h3
`define DBGBRK_ADDR_IRQ_CLR    4'h4
`define DBGBRK_CTRL_RESET      8'h00
`define DBGBRK_BIT_BP_EN       0
`define DBGBRK_BIT_LOOP_SEL    1
`define DBGBRK_BIT_DBG_REQ     2
`define DBGBRK_BIT_RESUME      3
`define DBGBRK_STAT_IDLE       0
`define DBGBRK_STAT_DEBUG      1
`define DBGBRK_STAT_IN_ISR     2
`define DBGBRK_EV_HALT         0
`define DBGBRK_EV_LOOP         1
`define DBGBRK_EV_IGNORED      2
`define DBGBRK_NUM_EV          3

`endif

// *** dbgbrk_pkg.sv ***
// dbgbrk_pkg.sv: types shared by the breakpoint control block
// assumes dbgbrk_params.svh is reachable by bare name
`include "dbgbrk_params.svh"

package dbgbrk_pkg;
    typedef enum logic [1:0] {
        DBGBRK_RUN,
        DBGBRK_LOOP,
        DBGBRK_STOP_PEND,
        DBGBRK_DEBUG
    } dbgbrk_state_t;
    typedef logic [7:0]                 dbgbrk_byte_t;
    typedef logic [`DBGBRK_ADDR_W-1:0]  dbgbrk_addr_t;
endpackage

// *** dbgbrk_decode.sv ***
// dbgbrk_decode.sv: spots the break opcode in the core's decode stage
// assumes opcode and decode_valid come from core logic on the same clock
`include "dbgbrk_params.svh"
`timescale 1ns/100ps
`default_nettype none

module dbgbrk_decode (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire dbgbrk_pkg::dbgbrk_byte_t opcode,
    input  wire logic                decode_valid,
    output logic                     break_indication
);
    import dbgbrk_pkg::*;

    wire is_break = decode_valid && (opcode == `DBGBRK_BREAK_OPCODE);

    always_ff @(posedge clk) begin
        if (rst) begin
            break_indication <= 1'b0;
        end else begin
            break_indication <= is_break;
        end
    end
endmodule // dbgbrk_decode

`default_nettype wire

// *** dbgbrk_ctrl.sv ***
// dbgbrk_ctrl.sv: breakpoint handling of the on-chip debug unit
// assumes core signals on clk; software on a plain strobe register port
//
// Added by the designer: the placing of the registers and strobed register access.
`include "dbgbrk_params.svh"
`timescale 1ns/100ps
`default_nettype none

module dbgbrk_ctrl (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire dbgbrk_pkg::dbgbrk_byte_t opcode,
    input  wire logic                     decode_valid,
    input  wire logic                     irq_pending,
    input  wire logic                     irq_enabled,
    input  wire logic                     dma_pending,
    input  wire logic                     isr_active,
    input  wire dbgbrk_pkg::dbgbrk_addr_t reg_addr,
    input  wire dbgbrk_pkg::dbgbrk_byte_t reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output dbgbrk_pkg::dbgbrk_byte_t      reg_rdata,
    output logic                          core_stall,
    output logic                          break_nop,
    output logic                          allow_irq,
    output logic                          allow_dma,
    output logic                          debug_mode,
    output logic                          irq_out
);
    import dbgbrk_pkg::*;

    dbgbrk_state_t state_reg;
    dbgbrk_state_t state_next;
    dbgbrk_byte_t  ctrl_reg;
    dbgbrk_byte_t  ctrl_next;
    logic [`DBGBRK_NUM_EV-1:0] ev_stat_reg;
    logic [`DBGBRK_NUM_EV-1:0] ev_en_reg;
    logic [`DBGBRK_NUM_EV-1:0] ev_set;
    logic [`DBGBRK_NUM_EV-1:0] ev_clr;
    logic          brk_ind;
    logic          stall_reg;
    logic          nop_reg;
    logic          allow_irq_reg;
    logic          allow_dma_reg;
    logic          debug_reg;
    logic          irq_reg;
    dbgbrk_byte_t  rdata_reg;
    dbgbrk_byte_t  rdata_next;

    dbgbrk_decode u_decode (
        .clk              (clk),
        .rst              (rst),
        .opcode           (opcode),
        .decode_valid     (decode_valid),
        .break_indication (brk_ind)
    );

    function automatic logic hit(input dbgbrk_addr_t a, input dbgbrk_addr_t t);
        hit = (a == t);
    endfunction

    wire bp_en    = ctrl_reg[`DBGBRK_BIT_BP_EN];
    wire loop_sel = ctrl_reg[`DBGBRK_BIT_LOOP_SEL];
    wire dbg_req  = ctrl_reg[`DBGBRK_BIT_DBG_REQ];
    wire wr_ctrl  = reg_wr && hit(reg_addr, `DBGBRK_ADDR_CTRL);
    wire wr_en    = reg_wr && hit(reg_addr, `DBGBRK_ADDR_IRQ_EN);
    wire wr_clr   = reg_wr && hit(reg_addr, `DBGBRK_ADDR_IRQ_CLR);
    wire resume   = wr_ctrl && reg_wdata[`DBGBRK_BIT_RESUME];
    wire in_loop  = (state_reg == DBGBRK_LOOP) || (state_reg == DBGBRK_STOP_PEND);
    // with bp_en set, a break met inside an irq routine halts, looping or not
    wire brk_halt = brk_ind && bp_en && (!loop_sel || isr_active);
    wire brk_loop = brk_ind && bp_en && loop_sel && !isr_active;
    wire brk_skip = brk_ind && !bp_en;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            DBGBRK_RUN: begin
                if (dbg_req || brk_halt) begin
                    state_next = DBGBRK_DEBUG;
                end else if (brk_loop) begin
                    state_next = DBGBRK_LOOP;
                end
            end
            DBGBRK_LOOP: begin
                if (brk_halt) begin
                    state_next = DBGBRK_DEBUG;
                end else if (!loop_sel) begin
                    state_next = DBGBRK_STOP_PEND;
                end
            end
            DBGBRK_STOP_PEND: begin
                // routine in flight must return to the break first
                if (!isr_active) begin
                    state_next = DBGBRK_DEBUG;
                end
            end
            DBGBRK_DEBUG: begin
                if (resume) begin
                    state_next = DBGBRK_RUN;
                end
            end
            default: state_next = DBGBRK_RUN;
        endcase
    end

    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next = reg_wdata;
            ctrl_next[`DBGBRK_BIT_RESUME] = 1'b0;
        end
        // request is consumed once debug mode is reached
        if (state_reg == DBGBRK_DEBUG) begin
            ctrl_next[`DBGBRK_BIT_DBG_REQ] = 1'b0;
        end
    end

    assign ev_set[`DBGBRK_EV_HALT]    = (state_next == DBGBRK_DEBUG) &&
                                        (state_reg != DBGBRK_DEBUG);
    assign ev_set[`DBGBRK_EV_LOOP]    = (state_next == DBGBRK_LOOP) &&
                                        (state_reg == DBGBRK_RUN);
    assign ev_set[`DBGBRK_EV_IGNORED] = brk_skip;
    assign ev_clr = wr_clr ? reg_wdata[`DBGBRK_NUM_EV-1:0] : '0;

    always_comb begin
        rdata_next = 8'h00;
        if (reg_rd) begin
            if (hit(reg_addr, `DBGBRK_ADDR_CTRL)) begin
                rdata_next = ctrl_reg;
            end else if (hit(reg_addr, `DBGBRK_ADDR_STAT)) begin
                rdata_next[`DBGBRK_STAT_IDLE]   = in_loop;
                rdata_next[`DBGBRK_STAT_DEBUG]  = (state_reg == DBGBRK_DEBUG);
                rdata_next[`DBGBRK_STAT_IN_ISR] = isr_active;
            end else if (hit(reg_addr, `DBGBRK_ADDR_IRQ_STAT)) begin
                rdata_next[`DBGBRK_NUM_EV-1:0] = ev_stat_reg;
            end else if (hit(reg_addr, `DBGBRK_ADDR_IRQ_EN)) begin
                rdata_next[`DBGBRK_NUM_EV-1:0] = ev_en_reg;
            end
        end
    end

    wire [`DBGBRK_NUM_EV-1:0] ev_stat_next = (ev_stat_reg & ~ev_clr) | ev_set;
    wire stall_next = (state_next == DBGBRK_DEBUG) ||
                      ((state_next != DBGBRK_RUN) && !irq_pending && !dma_pending);

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg     <= DBGBRK_RUN;
            ctrl_reg      <= `DBGBRK_CTRL_RESET;
            ev_stat_reg   <= '0;
            ev_en_reg     <= '0;
            stall_reg     <= 1'b0;
            nop_reg       <= 1'b0;
            allow_irq_reg <= 1'b0;
            allow_dma_reg <= 1'b0;
            debug_reg     <= 1'b0;
            irq_reg       <= 1'b0;
            rdata_reg     <= 8'h00;
        end else begin
            state_reg     <= state_next;
            ctrl_reg      <= ctrl_next;
            ev_stat_reg   <= ev_stat_next; // set wins over clear
            if (wr_en) begin
                ev_en_reg <= reg_wdata[`DBGBRK_NUM_EV-1:0];
            end
            stall_reg     <= stall_next;
            nop_reg       <= brk_skip;
            // looping core keeps taking dma; irqs only if software enabled them
            allow_irq_reg <= (state_next == DBGBRK_LOOP || state_next == DBGBRK_STOP_PEND)
                             && irq_enabled;
            allow_dma_reg <= (state_next != DBGBRK_DEBUG);
            debug_reg     <= (state_next == DBGBRK_DEBUG);
            irq_reg       <= |(ev_stat_next & ev_en_reg);
            rdata_reg     <= rdata_next;
        end
    end

    assign reg_rdata  = rdata_reg;
    assign core_stall = stall_reg;
    assign break_nop  = nop_reg;
    assign allow_irq  = allow_irq_reg;
    assign allow_dma  = allow_dma_reg;
    assign debug_mode = debug_reg;
    assign irq_out    = irq_reg;
endmodule // dbgbrk_ctrl

`default_nettype wire

// *** dbgbrk_ctrl_monitor.sv ***
// dbgbrk_ctrl_monitor.sv: port-level checks of the breakpoint control block
// assumes a bind onto dbgbrk_ctrl, one clock, synchronous reset
`timescale 1ns/100ps
`default_nettype none

module dbgbrk_ctrl_monitor (
    input wire logic                     clk,
    input wire logic                     rst,
    input wire dbgbrk_pkg::dbgbrk_byte_t opcode,
    input wire logic                     decode_valid,
    input wire logic                     irq_enabled,
    input wire logic                     reg_rd,
    input wire dbgbrk_pkg::dbgbrk_byte_t reg_rdata,
    input wire logic                     core_stall,
    input wire logic                     break_nop,
    input wire logic                     allow_irq,
    input wire logic                     allow_dma,
    input wire logic                     debug_mode
);
    import dbgbrk_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire logic brk_seen = decode_valid && (opcode == 8'h00);

    a_nop_after_brk: assert property (break_nop |-> $past(brk_seen, 2))
        else $error("break_nop without a break decode two cycles before");
    a_nop_no_halt: assert property (break_nop |-> !debug_mode)
        else $error("ignored break entered debug mode");
    a_stall_in_dbg: assert property (debug_mode |-> core_stall)
        else $error("core not held in debug mode");
    a_no_dma_dbg: assert property (debug_mode |-> !allow_dma)
        else $error("dma allowed in debug mode");
    a_dma_outside: assert property (!debug_mode && !$past(rst) |-> allow_dma)
        else $error("dma refused outside debug mode");
    a_irq_when_en: assert property (allow_irq |-> $past(irq_enabled))
        else $error("irq allowed while interrupts disabled");
    a_irq_not_dbg: assert property (allow_irq |-> !debug_mode)
        else $error("irq allowed in debug mode");
    a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside the read answer cycle");

    c_debug: cover property ($rose(debug_mode));
    c_loop_irq: cover property (allow_irq);
    c_nop: cover property (break_nop);
endmodule // dbgbrk_ctrl_monitor
`default_nettype wire

// *** dbgbrk_core_model.sv ***
// dbgbrk_core_model.sv: core decode stage, presents one opcode per request
// assumes bench requests on clk; off-request opcodes keep changing
`timescale 1ns/100ps
`default_nettype none

module dbgbrk_core_model (
    input  wire logic                     clk,
    input  wire logic                     req,
    input  wire dbgbrk_pkg::dbgbrk_byte_t req_op,
    output dbgbrk_pkg::dbgbrk_byte_t      opcode,
    output logic                          decode_valid
);
    import dbgbrk_pkg::*;
    initial opcode = 8'h5a;
    initial decode_valid = 1'b0;
    // idle opcode toggles so a stale value never passes for a decode
    always @(posedge clk) begin
        decode_valid <= req;
        opcode       <= req ? req_op : ~opcode;
    end
endmodule // dbgbrk_core_model
`default_nettype wire

// *** tb_top.sv ***
// tb_top.sv: register-task bench of the breakpoint control block
// assumes dbgbrk_ctrl, the core model and the monitor compiled before it
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import dbgbrk_pkg::*;
    logic         clk, rst, decode_valid, irq_pending, irq_enabled, dma_pending, isr_active;
    logic         reg_wr, reg_rd, core_stall, break_nop, allow_irq, allow_dma, debug_mode;
    logic         irq_out, req;
    dbgbrk_byte_t opcode, reg_wdata, reg_rdata, req_op;
    dbgbrk_addr_t reg_addr;
    int           n_errors, checked;

    always #20 clk = ~clk;
    dbgbrk_core_model u_dbgbrk_core_model (.clk(clk), .req(req), .req_op(req_op),
        .opcode(opcode), .decode_valid(decode_valid));
    dbgbrk_ctrl u_dbgbrk_ctrl (.clk(clk), .rst(rst), .opcode(opcode), .decode_valid(decode_valid),
        .irq_pending(irq_pending), .irq_enabled(irq_enabled), .dma_pending(dma_pending),
        .isr_active(isr_active), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_stall(core_stall), .break_nop(break_nop),
        .allow_irq(allow_irq), .allow_dma(allow_dma), .debug_mode(debug_mode), .irq_out(irq_out));

    task automatic report_and_stop();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input dbgbrk_addr_t a, input dbgbrk_byte_t d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input dbgbrk_addr_t a, input dbgbrk_byte_t exp, input string nm);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(nm, reg_rdata, exp);
    endtask
    // decode lands one edge after the request, outputs two edges later
    task automatic break_instruction(input dbgbrk_byte_t op, input logic nop, input logic dbg);
        @(posedge clk);
        req    <= 1'b1;
        req_op <= op;
        @(posedge clk);
        req <= 1'b0;
        w(2);
        chk("break_nop", 8'(break_nop), 8'(nop));
        chk("debug_mode", 8'(debug_mode), 8'(dbg));
    endtask

    initial begin
        #20000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        {clk, reg_wr, reg_rd, irq_pending, irq_enabled, dma_pending, isr_active, req} = '0;
        rst = 1'b1;
        reg_addr = '0;
        reg_wdata = '0;
        req_op = '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(4'h0, 8'h00, "ctrl");
        rd(4'hf, 8'h00, "unmapped");
        break_instruction(8'h00, 1'b1, 1'b0);
        rd(4'h2, 8'h04, "events");
        wr(4'h3, 8'h01);
        wr(4'h0, 8'h01);
        break_instruction(8'h3c, 1'b0, 1'b0);
        break_instruction(8'h00, 1'b0, 1'b1);
        rd(4'h1, 8'h02, "status");
        chk("irq_out", 8'(irq_out), 8'h01);
        wr(4'h4, 8'h07);
        rd(4'h2, 8'h00, "events");
        chk("irq_out", 8'(irq_out), 8'h00);
        wr(4'h0, 8'h0b);
        w(2);
        break_instruction(8'h00, 1'b0, 1'b0);
        rd(4'h1, 8'h01, "idle");
        chk("core_stall", 8'(core_stall), 8'h01);
        dma_pending <= 1'b1;
        w(2);
        chk("core_stall", 8'(core_stall), 8'h00);
        dma_pending <= 1'b0;
        irq_enabled <= 1'b1;
        irq_pending <= 1'b1;
        w(2);
        chk("allow_irq", 8'(allow_irq), 8'h01);
        irq_enabled <= 1'b0;
        w(2);
        chk("allow_irq", 8'(allow_irq), 8'h00);
        irq_pending <= 1'b0;
        isr_active <= 1'b1;
        wr(4'h0, 8'h01);
        w(3);
        chk("debug_mode", 8'(debug_mode), 8'h00);
        isr_active <= 1'b0;
        w(4);
        chk("debug_mode", 8'(debug_mode), 8'h01);
        wr(4'h3, 8'h00);
        w(2);
        chk("irq_out", 8'(irq_out), 8'h00);
        wr(4'h0, 8'h0b);
        w(2);
        isr_active <= 1'b1;
        break_instruction(8'h00, 1'b0, 1'b1);
        report_and_stop();
    end
endmodule // tb_top

bind dbgbrk_ctrl dbgbrk_ctrl_monitor u_dbgbrk_ctrl_monitor (.clk(clk), .rst(rst),
    .opcode(opcode), .decode_valid(decode_valid), .irq_enabled(irq_enabled), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .core_stall(core_stall), .break_nop(break_nop),
    .allow_irq(allow_irq), .allow_dma(allow_dma), .debug_mode(debug_mode));
`default_nettype wire
